/* hdl/mcss_map.vh */
// Register offsets, field positions, reset values and timing counts.
`ifndef MCSS_MAP_VH
`define MCSS_MAP_VH
`define MCSS_OFF_PIN_MODE 8'h00
`define MCSS_OFF_SYS_CTRL 8'h04
`define MCSS_OFF_RUN_CTRL 8'h08
`define MCSS_OFF_FREQ_SEL 8'h0c
`define MCSS_OFF_OPT_BYTE 8'h10
`define MCSS_PIN_EXT_BIT 7
`define MCSS_PIN_OSC_BIT 6
`define MCSS_SYS_STATUS_BIT 5
`define MCSS_SYS_SELECT_BIT 4
`define MCSS_RUN_RES_STOP_BIT 7
`define MCSS_RUN_FAST_STOP_BIT 0
`define MCSS_PIN_MODE_RST 8'h00
`define MCSS_SYS_CTRL_RST 8'h00
`define MCSS_RUN_CTRL_RST 8'hc0
`define MCSS_FREQ_SEL_RST 4'h0
`define MCSS_CODE_PORT 2'b00
`define MCSS_CODE_RESONATOR 2'b01
`define MCSS_CODE_PORT_ALT 2'b10
`define MCSS_CODE_EXTCLK 2'b11
`define MCSS_STABLE_NS 10000
`define MCSS_CLK_NS 10
`define MCSS_STABLE_CYC 16'd1000
`define MCSS_SYNC_STAGES 2
`endif

/* hdl/mcss_stable.v */
// Counts stable running cycles of an oscillator before reporting it ready.
`default_nettype none
module mcss_stable #(
    parameter [15:0] CYCLES = 16'd1000
) (
    input wire clk_sys,
    input wire rst,
    input wire running,
    output reg ready
);
    reg [15:0] cnt_r;

    // Any loss of the run indication restarts the wait.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= 16'h0000;
            ready <= 1'b0;
        end else if (!running) begin
            cnt_r <= 16'h0000;
            ready <= 1'b0;
        end else if (cnt_r >= CYCLES - 16'd1) begin
            ready <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'd1;
        end
    end
endmodule // mcss_stable
`default_nettype wire

/* hdl/mcss_sync.v */
// Two-flop synchroniser for one level from outside the clock domain.
`default_nettype none
module mcss_sync (
    input wire clk_sys,
    input wire rst,
    input wire din,
    output reg dout
);
    reg meta_r;

    // The first stage feeds only the second stage.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule // mcss_sync
`default_nettype wire

/* hdl/mcss_top.v */
// Main clock source selection with an AXI4-Lite register slave.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`default_nettype none
`include "mcss_map.vh"
module mcss_top (
    input wire clk_sys,
    input wire rst,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] boot_option_byte,
    input wire stop_mode,
    input wire resonator_clock_good,
    input wire fast_osc_clock_good,
    output reg fast_osc_enable,
    output reg [3:0] fast_osc_freq_code,
    output reg resonator_enable,
    output reg external_clock_enable,
    output reg osc_pin_a_port,
    output reg resonator_input_pin,
    output reg osc_pin_b_port,
    output reg resonator_output_pin,
    output reg external_clock_pin,
    output reg main_clock_source_status,
    output reg main_clock_gate_fast,
    output reg main_clock_gate_high
);
    localparam [1:0] ST_FAST = 2'd0;
    localparam [1:0] ST_WAIT_HIGH = 2'd1;
    localparam [1:0] ST_HIGH = 2'd2;
    localparam [1:0] ST_WAIT_FAST = 2'd3;
    localparam [15:0] STABLE_CYC = `MCSS_STABLE_CYC;

    reg [7:0] oscillator_pin_mode_control_r;
    reg pin_mode_written_r;
    reg [7:0] system_clock_control_r;
    reg [7:0] oscillator_run_control_r;
    reg [3:0] fast_osc_freq_select_r;
    reg freq_override_r;
    reg [7:0] option_byte_r;
    reg option_loaded_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg aw_held_r;
    reg aw_high_ok_r;
    reg w_held_r;
    reg [7:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    wire stop_sync;
    wire res_good_sync;
    wire fast_good_sync;
    wire res_ready;
    wire fast_ready;
    wire [1:0] pin_code;
    wire res_run;
    wire fast_run;
    wire do_write;
    wire sel_high;

    // All three fed by pins or other clocks, so they are synchronised first.
    mcss_sync u_sync_stop (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(stop_mode),
        .dout(stop_sync)
    );
    mcss_sync u_sync_res (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(resonator_clock_good),
        .dout(res_good_sync)
    );
    mcss_sync u_sync_fast (
        .clk_sys(clk_sys),
        .rst(rst),
        .din(fast_osc_clock_good),
        .dout(fast_good_sync)
    );

    // Switching only after the target has run steadily for a while.
    mcss_stable #(.CYCLES(STABLE_CYC)) u_res_stable (
        .clk_sys(clk_sys),
        .rst(rst),
        .running(res_good_sync & res_run),
        .ready(res_ready)
    );
    mcss_stable #(.CYCLES(STABLE_CYC)) u_fast_stable (
        .clk_sys(clk_sys),
        .rst(rst),
        .running(fast_good_sync & fast_run),
        .ready(fast_ready)
    );

    // Decodes a register byte address into a one-hot match.
    function is_addr;
        input [7:0] addr;
        input [7:0] offset;
        begin
            is_addr = (addr == offset);
        end
    endfunction

    assign pin_code = {oscillator_pin_mode_control_r[`MCSS_PIN_EXT_BIT],
                       oscillator_pin_mode_control_r[`MCSS_PIN_OSC_BIT]};
    assign fast_run = !stop_sync &&
        !oscillator_run_control_r[`MCSS_RUN_FAST_STOP_BIT];
    assign res_run = !stop_sync &&
        !oscillator_run_control_r[`MCSS_RUN_RES_STOP_BIT];
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    assign sel_high = system_clock_control_r[`MCSS_SYS_SELECT_BIT];

    // Write channel: address and data captured in either order.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_high_ok_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !aw_held_r && !s_axi_awready) begin
                s_axi_awready <= 1'b1;
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr[7:0];
                aw_high_ok_r <= (s_axi_awaddr[31:8] == 24'h000000);
            end
            if (s_axi_wvalid && !w_held_r && !s_axi_wready) begin
                s_axi_wready <= 1'b1;
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_high_ok_r &&
                    (is_addr(aw_addr_r, `MCSS_OFF_PIN_MODE) ||
                     is_addr(aw_addr_r, `MCSS_OFF_SYS_CTRL) ||
                     is_addr(aw_addr_r, `MCSS_OFF_RUN_CTRL) ||
                     is_addr(aw_addr_r, `MCSS_OFF_FREQ_SEL) ||
                     is_addr(aw_addr_r, `MCSS_OFF_OPT_BYTE)))
                    ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
        end
    end

    // Register updates; only the low byte lane carries register data.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            oscillator_pin_mode_control_r <= `MCSS_PIN_MODE_RST;
            pin_mode_written_r <= 1'b0;
            system_clock_control_r <= `MCSS_SYS_CTRL_RST;
            oscillator_run_control_r <= `MCSS_RUN_CTRL_RST;
            fast_osc_freq_select_r <= `MCSS_FREQ_SEL_RST;
            freq_override_r <= 1'b0;
        end else if (do_write && w_strb_r[0] && aw_high_ok_r) begin
            if (is_addr(aw_addr_r, `MCSS_OFF_PIN_MODE)) begin
                if (!pin_mode_written_r) begin
                    oscillator_pin_mode_control_r <=
                        {w_data_r[7:6], 5'b00000, w_data_r[0]};
                    pin_mode_written_r <= 1'b1;
                end
            end else if (is_addr(aw_addr_r, `MCSS_OFF_SYS_CTRL)) begin
                system_clock_control_r <=
                    {3'b000, w_data_r[4], 4'h0};
            end else if (is_addr(aw_addr_r, `MCSS_OFF_RUN_CTRL)) begin
                oscillator_run_control_r <=
                    {w_data_r[7:6], 5'b00000, w_data_r[0]};
            end else if (is_addr(aw_addr_r, `MCSS_OFF_FREQ_SEL)) begin
                fast_osc_freq_select_r <= w_data_r[3:0];
                freq_override_r <= 1'b1;
            end
        end
    end

    // The option byte is caught once, after reset release.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            option_byte_r <= 8'h00;
            option_loaded_r <= 1'b0;
        end else if (!option_loaded_r) begin
            option_byte_r <= boot_option_byte;
            option_loaded_r <= 1'b1;
        end
    end

    // Read channel answers in the same cycle that arready takes the address.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
            end else if (s_axi_arvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                s_axi_rdata <= 32'h00000000;
                if (s_axi_araddr[31:8] != 24'h000000) begin
                    s_axi_rresp <= 2'b10;
                end else if (is_addr(s_axi_araddr[7:0],
                        `MCSS_OFF_PIN_MODE)) begin
                    s_axi_rdata <= {24'h000000,
                        oscillator_pin_mode_control_r};
                end else if (is_addr(s_axi_araddr[7:0],
                        `MCSS_OFF_SYS_CTRL)) begin
                    s_axi_rdata <= {24'h000000, 2'b00,
                        main_clock_source_status, sel_high,
                        4'h0};
                end else if (is_addr(s_axi_araddr[7:0],
                        `MCSS_OFF_RUN_CTRL)) begin
                    s_axi_rdata <= {24'h000000,
                        oscillator_run_control_r};
                end else if (is_addr(s_axi_araddr[7:0],
                        `MCSS_OFF_FREQ_SEL)) begin
                    s_axi_rdata <= {28'h0000000, fast_osc_freq_code};
                end else if (is_addr(s_axi_araddr[7:0],
                        `MCSS_OFF_OPT_BYTE)) begin
                    s_axi_rdata <= {24'h000000, option_byte_r};
                end else begin
                    s_axi_rresp <= 2'b10;
                end
            end
        end
    end

    // Break-before-make switch: old gate drops, then wait for target.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_FAST: begin
                if (sel_high) begin
                    state_nxt = ST_WAIT_HIGH;
                end
            end
            ST_WAIT_HIGH: begin
                if (!sel_high) begin
                    state_nxt = ST_WAIT_FAST;
                end else if (res_ready && res_run) begin
                    state_nxt = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (!sel_high || !res_ready) begin
                    state_nxt = ST_WAIT_FAST;
                end
            end
            default: begin
                if (fast_ready && fast_run) begin
                    state_nxt = ST_FAST;
                end
            end
        endcase
    end

    // Clock gates and status come straight from flops.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= ST_FAST;
            main_clock_gate_fast <= 1'b1;
            main_clock_gate_high <= 1'b0;
            main_clock_source_status <= 1'b0;
        end else begin
            state_r <= state_nxt;
            main_clock_gate_fast <= (state_nxt == ST_FAST);
            main_clock_gate_high <= (state_nxt == ST_HIGH);
            main_clock_source_status <= (state_nxt == ST_HIGH);
        end
    end

    // Oscillator enables, frequency choice and pin functions.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fast_osc_enable <= 1'b1;
            fast_osc_freq_code <= 4'h0;
            resonator_enable <= 1'b0;
            external_clock_enable <= 1'b0;
            osc_pin_a_port <= 1'b1;
            resonator_input_pin <= 1'b0;
            osc_pin_b_port <= 1'b1;
            resonator_output_pin <= 1'b0;
            external_clock_pin <= 1'b0;
        end else begin
            // Fast oscillator is never stopped while it drives the CPU.
            fast_osc_enable <= fast_run ||
                main_clock_gate_fast;
            fast_osc_freq_code <= freq_override_r ?
                fast_osc_freq_select_r : option_byte_r[3:0];
            resonator_enable <= res_run &&
                (pin_code == `MCSS_CODE_RESONATOR);
            external_clock_enable <= res_run &&
                (pin_code == `MCSS_CODE_EXTCLK);
            osc_pin_a_port <= (pin_code != `MCSS_CODE_RESONATOR);
            resonator_input_pin <=
                (pin_code == `MCSS_CODE_RESONATOR);
            osc_pin_b_port <= (pin_code == `MCSS_CODE_PORT) ||
                (pin_code == `MCSS_CODE_PORT_ALT);
            resonator_output_pin <=
                (pin_code == `MCSS_CODE_RESONATOR);
            external_clock_pin <= (pin_code == `MCSS_CODE_EXTCLK);
        end
    end
endmodule // mcss_top
`default_nettype wire

/* testbench/mcss_osc_model.sv */
// Behavioural oscillators on the far side of the clock source selector.
`default_nettype none
module mcss_osc_model #(
    parameter int START_CYC = 20
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic resonator_enable,
    input wire logic external_clock_enable,
    input wire logic fast_osc_enable,
    output logic resonator_clock_good,
    output logic fast_osc_clock_good
);
    timeunit 1ns;
    timeprecision 1ps;
    int res_cnt;
    int fast_cnt;
    // A crystal needs time to build up, an external clock is prompt.
    // Good drops one cycle after disable, when the count clears, so a stopped source does not stay live.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            res_cnt <= 0;
            fast_cnt <= 0;
        end else begin
            res_cnt <= !(resonator_enable || external_clock_enable) ? 0 :
                (res_cnt < START_CYC) ? res_cnt + 1 : res_cnt;
            fast_cnt <= !fast_osc_enable ? 0 :
                (fast_cnt < START_CYC) ? fast_cnt + 1 : fast_cnt;
        end
    end
    assign resonator_clock_good = external_clock_enable ? (res_cnt >= 2) :
        (res_cnt >= START_CYC);
    assign fast_osc_clock_good = fast_cnt >= START_CYC;
endmodule // mcss_osc_model
`default_nettype wire

/* testbench/mcss_top_assertions.sv */
// Checker for the outputs of the clock source selector.
`default_nettype none
module mcss_top_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic stop_mode,
    input wire logic fast_osc_enable,
    input wire logic resonator_enable,
    input wire logic external_clock_enable,
    input wire logic osc_pin_a_port,
    input wire logic resonator_input_pin,
    input wire logic osc_pin_b_port,
    input wire logic resonator_output_pin,
    input wire logic external_clock_pin,
    input wire logic main_clock_source_status,
    input wire logic main_clock_gate_fast,
    input wire logic main_clock_gate_high
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Two open gates at once would glitch the main clock.
    a_gates_exclusive: assert property (
        !(main_clock_gate_fast && main_clock_gate_high))
        else $error("both main clock gates open");
    // The processor leaves reset on the fast oscillator.
    a_reset_on_fast: assert property ($fell(rst) |->
        main_clock_gate_fast && !main_clock_gate_high)
        else $error("main clock not on fast oscillator after reset");
    // The fast oscillator cannot be gated while stopped.
    a_fast_runs_gated: assert property (
        main_clock_gate_fast |-> fast_osc_enable)
        else $error("fast gate open with fast oscillator stopped");
    // Pin A is either a port or the resonator input, never both.
    a_pin_a_mode: assert property (
        osc_pin_a_port != resonator_input_pin)
        else $error("pin A mode not exclusive");
    // Pin B carries exactly one function.
    a_pin_b_mode: assert property ($onehot({osc_pin_b_port,
        resonator_output_pin, external_clock_pin}))
        else $error("pin B mode not exclusive");
    // Both resonator pins switch together.
    a_res_pin_pair: assert property (
        resonator_input_pin == resonator_output_pin)
        else $error("resonator pins disagree");
    // An oscillator only runs in the pin mode that it needs.
    a_res_needs_mode: assert property (
        (resonator_enable |-> resonator_input_pin) and
        (external_clock_enable |-> external_clock_pin))
        else $error("high-speed source enabled in wrong pin mode");
    // A held stop request halts the high-speed sources.
    a_stop_halts: assert property (stop_mode [*5] |->
        !resonator_enable && !external_clock_enable)
        else $error("high-speed source running in stop mode");
    // The high gate opens only onto a running source.
    a_high_has_source: assert property (
        $rose(main_clock_gate_high) |->
        resonator_enable || external_clock_enable)
        else $error("high gate opened on stopped source");
    // Status follows the high gate within two cycles.
    a_status_follows: assert property (
        $rose(main_clock_gate_high) |-> ##[0:2] main_clock_source_status)
        else $error("status did not report high-speed clock");
endmodule // mcss_top_chk

bind mcss_top mcss_top_chk u_chk (.clk_sys(clk_sys), .rst(rst),
    .stop_mode(stop_mode), .fast_osc_enable(fast_osc_enable),
    .resonator_enable(resonator_enable),
    .external_clock_enable(external_clock_enable),
    .osc_pin_a_port(osc_pin_a_port),
    .resonator_input_pin(resonator_input_pin),
    .osc_pin_b_port(osc_pin_b_port),
    .resonator_output_pin(resonator_output_pin),
    .external_clock_pin(external_clock_pin),
    .main_clock_source_status(main_clock_source_status),
    .main_clock_gate_fast(main_clock_gate_fast),
    .main_clock_gate_high(main_clock_gate_high));
`default_nettype wire

/* testbench/mcss_top_test.sv */
// Register-level testbench for the clock source selector.
`include "mcss_map.vh"
`default_nettype none
module mcss_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stop_mode = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic res_good, fast_good, fast_en, res_en, ext_en, pa_port, res_in;
    logic pb_port, res_out, ext_pin, status, gate_fast, gate_high;
    logic [3:0] freq_code;
    logic [7:0] boot_byte = 8'h25;
    int err_total = 0;
    int num_checks = 0;

    always #5 clk_sys = ~clk_sys;

    mcss_top DUT (.clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .boot_option_byte(boot_byte),
        .stop_mode(stop_mode), .resonator_clock_good(res_good),
        .fast_osc_clock_good(fast_good), .fast_osc_enable(fast_en),
        .fast_osc_freq_code(freq_code), .resonator_enable(res_en),
        .external_clock_enable(ext_en), .osc_pin_a_port(pa_port),
        .resonator_input_pin(res_in), .osc_pin_b_port(pb_port),
        .resonator_output_pin(res_out), .external_clock_pin(ext_pin),
        .main_clock_source_status(status),
        .main_clock_gate_fast(gate_fast), .main_clock_gate_high(gate_high));

    mcss_osc_model u_osc (.clk_sys(clk_sys), .rst(rst),
        .resonator_enable(res_en), .external_clock_enable(ext_en),
        .fast_osc_enable(fast_en), .resonator_clock_good(res_good),
        .fast_osc_clock_good(fast_good));

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset;
        rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    // Both channels are offered together and released as each is taken.
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        s_axi_bready <= 1'b0;
        chk("write response", 32'h1, {31'h0, s_axi_bvalid === 1'b1});
        // Unmapped or unaligned offsets must be refused with SLVERR.
        chk("write bresp", (a > `MCSS_OFF_OPT_BYTE || a[1:0] != 2'b00) ?
            32'h2 : 32'h0, {30'h0, s_axi_bresp});
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] exp,
        input logic [1:0] resp);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        s_axi_rready <= 1'b0;
        chk("read valid", 32'h1, {31'h0, s_axi_rvalid === 1'b1});
        chk("read resp", {30'h0, resp}, {30'h0, s_axi_rresp});
        if (resp === 2'b00) chk("read data", exp, s_axi_rdata);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog sized well above the two clock switches and resets.
    initial begin
        repeat (50000) @(posedge clk_sys);
        err_total++;
        $display("watchdog expired");
        tally_and_finish;
    end

    initial begin
        logic [1:0] c;
        int n;
        do_reset;
        chk("gate fast", 32'h1, {31'h0, gate_fast});
        axr(`MCSS_OFF_RUN_CTRL, 32'hc0, 2'b00);
        axr(`MCSS_OFF_SYS_CTRL, 32'h00, 2'b00);
        axr(`MCSS_OFF_OPT_BYTE, 32'h25, 2'b00);
        chk("freq code", 32'h5, {28'h0, freq_code});
        axw(`MCSS_OFF_FREQ_SEL, 32'h3);
        repeat (2) @(posedge clk_sys);
        chk("freq code", 32'h3, {28'h0, freq_code});
        axr(8'h20, 32'h0, 2'b10);
        axw(8'h20, 32'hff);
        axr(`MCSS_OFF_RUN_CTRL, 32'hc0, 2'b00);
        $display("test reset_and_freq done");
        // Every pin code from a fresh reset, then a refused rewrite.
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            do_reset;
            axw(`MCSS_OFF_PIN_MODE, {24'h0, c, 6'h0});
            axw(`MCSS_OFF_RUN_CTRL, 32'h0);
            repeat (3) @(posedge clk_sys);
            chk("pin a port", c != 2'b01, pa_port);
            chk("res in", c == 2'b01, res_in);
            chk("pin b port", !c[0], pb_port);
            chk("res out", c == 2'b01, res_out);
            chk("ext pin", c == 2'b11, ext_pin);
            chk("res en", c == 2'b01, res_en);
            chk("ext en", c == 2'b11, ext_en);
            axw(`MCSS_OFF_PIN_MODE, {24'h0, ~c, 6'h0});
            axr(`MCSS_OFF_PIN_MODE, {24'h0, c, 6'h0}, 2'b00);
            stop_mode <= 1'b1;
            repeat (6) @(posedge clk_sys);
            chk("stop res en", 32'h0, {31'h0, res_en || ext_en});
            stop_mode <= 1'b0;
        end
        axw(`MCSS_OFF_RUN_CTRL, 32'h80);
        repeat (3) @(posedge clk_sys);
        chk("stop bit ext en", 32'h0, {31'h0, ext_en});
        $display("test pin_modes done");
        do_reset;
        axw(`MCSS_OFF_PIN_MODE, 32'h40);
        axw(`MCSS_OFF_RUN_CTRL, 32'h0);
        axw(`MCSS_OFF_SYS_CTRL, 32'h10);
        n = 0;
        while (gate_high !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        chk("gate high", 32'h1, {31'h0, gate_high});
        axr(`MCSS_OFF_SYS_CTRL, 32'h30, 2'b00);
        axw(`MCSS_OFF_RUN_CTRL, 32'h01);
        repeat (3) @(posedge clk_sys);
        chk("fast en", 32'h0, {31'h0, fast_en});
        axw(`MCSS_OFF_RUN_CTRL, 32'h0);
        axw(`MCSS_OFF_SYS_CTRL, 32'h0);
        n = 0;
        while (gate_fast !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        chk("gate back", 32'h1, {31'h0, gate_fast && !gate_high});
        axr(`MCSS_OFF_SYS_CTRL, 32'h00, 2'b00);
        $display("test clock_switch done");
        tally_and_finish;
    end
endmodule // mcss_top_test
`default_nettype wire
